// ==== common/fab_pkg.sv ====
// fab_pkg: register map, field positions, reset values and types of the
// flag, addressing and branch unit
// assumes a 32-bit Avalon-MM register window addressed in bytes
`default_nettype none
package fab_pkg;
  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] PC_OFS = 8'h00;
  localparam logic [7:0] CMD_OFS = 8'h04;
  localparam logic [7:0] OPA_OFS = 8'h08;
  localparam logic [7:0] OPB_OFS = 8'h0C;
  localparam logic [7:0] RES_OFS = 8'h10;
  localparam logic [7:0] SP_OFS = 8'h14;
  localparam logic [7:0] DATA_POINTER_OFS = 8'h18;
  localparam logic [7:0] PSW_OFS = 8'hD0;
  localparam logic [7:0] ACC_OFS = 8'hE0;
  // ----------------------------------------------------------------
  // status flag register fields
  // ----------------------------------------------------------------
  localparam int CY_BIT = 7;
  localparam int AC_BIT = 6;
  localparam int UF_BIT = 5;
  localparam int BS_HI_BIT = 4;
  localparam int BS_LO_BIT = 3;
  localparam int OV_BIT = 2;
  localparam int BIT_TEST_SRC = 6;
  localparam logic [7:0] PSW_WR_MASK = 8'hFC;
  // ----------------------------------------------------------------
  // reset values and instruction lengths
  // ----------------------------------------------------------------
  localparam logic [15:0] PC_RST = 16'h0000;
  localparam logic [15:0] DATA_POINTER_RST = 16'h0000;
  localparam logic [7:0] PSW_RST = 8'h00;
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [7:0] SP_RST = 8'h07;
  localparam logic [1:0] LEN1 = 2'h1;
  localparam logic [1:0] LEN2 = 2'h2;
  localparam logic [1:0] LEN3 = 2'h3;
  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [5:0] {
    OP_NOP, OP_ADD, OP_ADD_CARRY, OP_SUB_BORROW, OP_ROT_LEFT_C, OP_ROT_RIGHT_C,
    OP_CLEAR_OVF, OP_BIT_TEST, OP_AND_C_BIT, OP_AND_C_NBIT, OP_OR_C_BIT,
    OP_OR_C_NBIT, OP_MOVE_TO_C, OP_MOVE_FROM_C, OP_CLR_CARRY, OP_CLR_BIT,
    OP_SET_CARRY, OP_SET_BIT, OP_CMPL_CARRY, OP_CMPL_BIT, OP_JUMP_CARRY_SET,
    OP_JUMP_CARRY_CLEAR, OP_JUMP_BIT_SET, OP_JUMP_BIT_CLEAR,
    OP_JUMP_BIT_AND_CLEAR, OP_JUMP_ACC_ZERO, OP_JUMP_ACC_NONZERO,
    OP_DECREMENT_BRANCH, OP_COMPARE_BRANCH, OP_SHORT_JUMP, OP_LONG_JUMP,
    OP_ABSOLUTE_JUMP, OP_JUMP_INDEXED, OP_SUBROUTINE_RETURN,
    OP_INTERRUPT_RETURN, OP_IND_BANK_REG, OP_IND_STACK, OP_IND_POINTER,
    OP_REG_DIRECT, OP_FETCH_INDEX_PTR, OP_FETCH_INDEX_PC
  } fab_op_e;
  typedef struct packed {
    logic [12:0] spare;
    logic [2:0] sel;
    logic [7:0] rel;
    logic [1:0] pad;
    fab_op_e op;
  } fab_cmd_s;
  typedef struct packed {
    logic [15:0] addr;
    logic [6:0] pad;
    logic taken;
    logic [7:0] data;
  } fab_res_s;
endpackage
`default_nettype wire

// ==== hdl/fab_core.sv ====
// fab_core: program counter, status flags, data pointer and the branch,
// boolean and addressing operations, reached over Avalon-MM
// assumes one 40 MHz clock, a synchronous active-high reset, and software
// that supplies memory operands and fetches the addresses it reports
//
// Functional notes
// RULE1: 16-bit program counter, high and low bytes, reset to zero
// RULE2: carry takes carry out or inverted borrow; rotates update it
// RULE3: aux carry set on carry out of bit 3, no borrow from 4
// RULE4: two bank selects pick one of four eight-byte banks
// RULE5: overflow set when signed result above +127 or below -128
// RULE6: clear-overflow op clears it; bit test copies bit 6
// RULE7: parity reads 0 for odd accumulator weight, 1 otherwise
// RULE8: 16-bit data pointer of two bytes addresses external data
// RULE9: 8-bit indirect via R0, R1 or stack; 16-bit only via pointer
// RULE10: 3-bit opcode field selects a register of the current bank
// RULE11: indexed access reads program memory at base plus accumulator
// RULE12: taken relative jump adds signed offset to next address
// RULE13: short jump is two bytes; long and absolute differ in target
// RULE14: carry boolean ops: and, or, move, clear, set, complement
// RULE15: branch on carry or bit; bit-and-clear clears taken bit
// RULE16: interrupt return acts as plain subroutine return
// RULE17: no zero flag; zero jumps test the accumulator directly
// RULE18: decrement counter, branch only when result is non-zero
// RULE19: compare branches on inequality; carry means first below second
// RULE20: status layout carry 7 down to parity 0, reset to zero
// RULE21: user flag is software only, never touched by operations
`timescale 1ns/100ps
`default_nettype none
module fab_core
  import fab_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic [7:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  output logic [15:0] o_pc,
  output logic [1:0] o_bank_sel
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic wait_q;
  logic [31:0] rdata_q;
  logic [15:0] pc_q, pc_d;
  logic [15:0] data_pointer_q;
  logic [15:0] opb_q;
  logic [7:0] psw_q, psw_d;
  logic [7:0] acc_q, acc_d;
  logic [7:0] sp_q, sp_d;
  logic [7:0] opa_q;
  fab_cmd_s cmd_q;
  fab_res_s res_q, res_d;
  logic exec_q;
  logic req, take_req, wr_acc, exec;
  logic [31:0] rd_mux, wval;
  fab_cmd_s cmd;
  logic [7:0] psw_rd;
  logic [1:0] ilen;
  logic [15:0] pc_seq, rel_tgt;
  logic [7:0] addend;
  logic cin, ovf, br, bitv, cy;
  logic [8:0] sum9;
  logic [4:0] sum5;

  // ----------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------
  // each access waits one cycle, so read data is always registered
  assign req = i_avs_read | i_avs_write;
  assign take_req = req & ~wait_q;
  assign wr_acc = i_avs_write & take_req;
  assign exec = wr_acc && (i_avs_address == CMD_OFS);
  assign psw_rd = {psw_q[7:2], 1'b0, ~^acc_q}; // RULE7 RULE20

  always_comb begin
    case (i_avs_address)
      PC_OFS: rd_mux = {16'h0000, pc_q};
      CMD_OFS: rd_mux = cmd_q;
      OPA_OFS: rd_mux = {24'h000000, opa_q};
      OPB_OFS: rd_mux = {16'h0000, opb_q};
      RES_OFS: rd_mux = res_q;
      SP_OFS: rd_mux = {24'h000000, sp_q};
      DATA_POINTER_OFS: rd_mux = {16'h0000, data_pointer_q};
      PSW_OFS: rd_mux = {24'h000000, psw_rd};
      ACC_OFS: rd_mux = {24'h000000, acc_q};
      default: rd_mux = 32'h00000000;
    endcase
  end

  // unselected byte lanes keep the register's current contents
  for (genvar g = 0; g < 4; g++) begin : g_lane
    assign wval[g*8 +: 8] = i_avs_byteenable[g] ? i_avs_writedata[g*8 +: 8]
                                                : rd_mux[g*8 +: 8];
  end
  assign cmd = fab_cmd_s'(wval);

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      wait_q <= 1'b1;
      rdata_q <= 32'h00000000;
    end else begin
      wait_q <= ~(req & wait_q);
      if (i_avs_read && wait_q) begin
        rdata_q <= rd_mux;
      end
    end
  end

  assign o_avs_waitrequest = wait_q;
  assign o_avs_readdata = rdata_q;
  assign o_pc = pc_q;
  assign o_bank_sel = psw_q[BS_HI_BIT:BS_LO_BIT];

  // ----------------------------------------------------------------
  // arithmetic and address formation
  // ----------------------------------------------------------------
  always_comb begin
    case (cmd.op)
      OP_ADD, OP_ADD_CARRY, OP_SUB_BORROW, OP_BIT_TEST: ilen = LEN2;
      OP_CLR_BIT, OP_SET_BIT, OP_CMPL_BIT, OP_MOVE_TO_C: ilen = LEN2;
      OP_AND_C_BIT, OP_AND_C_NBIT, OP_OR_C_BIT, OP_OR_C_NBIT: ilen = LEN2;
      OP_MOVE_FROM_C, OP_JUMP_CARRY_SET, OP_JUMP_CARRY_CLEAR: ilen = LEN2;
      OP_JUMP_ACC_ZERO, OP_JUMP_ACC_NONZERO, OP_ABSOLUTE_JUMP: ilen = LEN2;
      OP_SHORT_JUMP: ilen = LEN2; // RULE13
      OP_JUMP_BIT_SET, OP_JUMP_BIT_CLEAR, OP_JUMP_BIT_AND_CLEAR: ilen = LEN3;
      OP_DECREMENT_BRANCH, OP_COMPARE_BRANCH, OP_LONG_JUMP: ilen = LEN3;
      default: ilen = LEN1;
    endcase
  end

  // subtraction adds the inverted operand, so carry out means no borrow
  assign addend = (cmd.op == OP_SUB_BORROW) ? ~opa_q : opa_q;
  assign cin = (cmd.op == OP_ADD) ? 1'b0 : psw_q[CY_BIT];
  assign sum9 = {1'b0, acc_q} + {1'b0, addend} + {8'h00, cin};
  assign sum5 = {1'b0, acc_q[3:0]} + {1'b0, addend[3:0]} + {4'h0, cin};
  assign ovf = (acc_q[7] == addend[7]) && (sum9[7] != acc_q[7]); // RULE5
  assign pc_seq = pc_q + {14'h0000, ilen};
  assign rel_tgt = pc_seq + {{8{cmd.rel[7]}}, cmd.rel}; // RULE12
  assign bitv = opa_q[0];
  assign cy = psw_q[CY_BIT];

  // ----------------------------------------------------------------
  // operation decode
  // ----------------------------------------------------------------
  always_comb begin
    pc_d = pc_seq;
    psw_d = psw_q;
    acc_d = acc_q;
    sp_d = sp_q;
    res_d = '0;
    br = 1'b0;
    case (cmd.op)
      OP_ADD, OP_ADD_CARRY, OP_SUB_BORROW: begin
        acc_d = sum9[7:0];
        psw_d[CY_BIT] = sum9[8]; // RULE2
        psw_d[AC_BIT] = sum5[4]; // RULE3
        psw_d[OV_BIT] = ovf; // RULE5
      end
      OP_ROT_LEFT_C: begin
        acc_d = {acc_q[6:0], cy};
        psw_d[CY_BIT] = acc_q[7]; // RULE2
      end
      OP_ROT_RIGHT_C: begin
        acc_d = {cy, acc_q[7:1]};
        psw_d[CY_BIT] = acc_q[0]; // RULE2
      end
      OP_CLEAR_OVF: psw_d[OV_BIT] = 1'b0; // RULE6
      OP_BIT_TEST: psw_d[OV_BIT] = opa_q[BIT_TEST_SRC]; // RULE6
      OP_AND_C_BIT: psw_d[CY_BIT] = cy & bitv; // RULE14
      OP_AND_C_NBIT: psw_d[CY_BIT] = cy & ~bitv; // RULE14
      OP_OR_C_BIT: psw_d[CY_BIT] = cy | bitv; // RULE14
      OP_OR_C_NBIT: psw_d[CY_BIT] = cy | ~bitv; // RULE14
      OP_MOVE_TO_C: psw_d[CY_BIT] = bitv; // RULE14
      OP_MOVE_FROM_C: res_d.data = {7'h00, cy}; // RULE14
      OP_CLR_CARRY: psw_d[CY_BIT] = 1'b0; // RULE14
      OP_CLR_BIT: res_d.data = 8'h00; // RULE14
      OP_SET_CARRY: psw_d[CY_BIT] = 1'b1; // RULE14
      OP_SET_BIT: res_d.data = 8'h01; // RULE14
      OP_CMPL_CARRY: psw_d[CY_BIT] = ~cy; // RULE14
      OP_CMPL_BIT: res_d.data = {7'h00, ~bitv}; // RULE14
      OP_JUMP_CARRY_SET: br = cy; // RULE15
      OP_JUMP_CARRY_CLEAR: br = ~cy; // RULE15
      OP_JUMP_BIT_SET: begin
        br = bitv; // RULE15
        res_d.data = {7'h00, bitv};
      end
      OP_JUMP_BIT_CLEAR: begin
        br = ~bitv; // RULE15
        res_d.data = {7'h00, bitv};
      end
      // the bit ends clear either way: taken means it was set
      OP_JUMP_BIT_AND_CLEAR: begin
        br = bitv; // RULE15
        res_d.data = 8'h00; // RULE15
      end
      OP_JUMP_ACC_ZERO: br = (acc_q == 8'h00); // RULE17
      OP_JUMP_ACC_NONZERO: br = (acc_q != 8'h00); // RULE17
      OP_DECREMENT_BRANCH: begin
        res_d.data = opa_q - 8'h01; // RULE18
        br = (opa_q != 8'h01); // RULE18
      end
      OP_COMPARE_BRANCH: begin
        br = (opa_q != opb_q[7:0]); // RULE19
        psw_d[CY_BIT] = (opa_q < opb_q[7:0]); // RULE19
      end
      OP_SHORT_JUMP: br = 1'b1; // RULE13
      OP_LONG_JUMP: pc_d = opb_q; // RULE13
      OP_ABSOLUTE_JUMP: pc_d = {pc_seq[15:11], opb_q[10:0]}; // RULE13
      OP_JUMP_INDEXED: pc_d = data_pointer_q + {8'h00, acc_q};
      // no interrupt state is kept here, so both returns behave alike
      OP_SUBROUTINE_RETURN, OP_INTERRUPT_RETURN: begin
        pc_d = opb_q; // RULE16
        sp_d = sp_q - 8'h02; // RULE16
      end
      OP_IND_BANK_REG: begin
        res_d.addr = {8'h00, opa_q}; // RULE9
        res_d.data = {3'h0, psw_q[BS_HI_BIT:BS_LO_BIT], 2'h0, cmd.sel[0]}; // RULE4
      end
      OP_IND_STACK: res_d.addr = {8'h00, sp_q}; // RULE9
      OP_IND_POINTER: res_d.addr = data_pointer_q; // RULE9 RULE8
      OP_REG_DIRECT: res_d.addr = {11'h000, psw_q[BS_HI_BIT:BS_LO_BIT], cmd.sel}; // RULE10
      OP_FETCH_INDEX_PTR: res_d.addr = data_pointer_q + {8'h00, acc_q}; // RULE11
      OP_FETCH_INDEX_PC: res_d.addr = pc_seq + {8'h00, acc_q}; // RULE11
      default: begin
      end
    endcase
    if (br) begin
      pc_d = rel_tgt; // RULE12
    end
    res_d.taken = br;
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      pc_q <= PC_RST; // RULE1
    end else if (exec) begin
      pc_q <= pc_d;
    end else if (wr_acc && (i_avs_address == PC_OFS)) begin
      pc_q <= wval[15:0];
    end
  end

  // parity is derived, reserved bit reads zero, user flag is kept as is
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      psw_q <= PSW_RST; // RULE20
    end else if (exec) begin
      psw_q <= psw_d & PSW_WR_MASK; // RULE21
    end else if (wr_acc && (i_avs_address == PSW_OFS)) begin
      psw_q <= wval[7:0] & PSW_WR_MASK; // RULE21
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      acc_q <= ACC_RST;
    end else if (exec) begin
      acc_q <= acc_d;
    end else if (wr_acc && (i_avs_address == ACC_OFS)) begin
      acc_q <= wval[7:0];
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      sp_q <= SP_RST;
    end else if (exec) begin
      sp_q <= sp_d;
    end else if (wr_acc && (i_avs_address == SP_OFS)) begin
      sp_q <= wval[7:0];
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      data_pointer_q <= DATA_POINTER_RST; // RULE8
      opa_q <= 8'h00;
      opb_q <= 16'h0000;
    end else if (wr_acc) begin
      if (i_avs_address == DATA_POINTER_OFS) begin
        data_pointer_q <= wval[15:0]; // RULE8
      end
      if (i_avs_address == OPA_OFS) begin
        opa_q <= wval[7:0];
      end
      if (i_avs_address == OPB_OFS) begin
        opb_q <= wval[15:0];
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      cmd_q <= '0;
      res_q <= '0;
      exec_q <= 1'b0;
    end else begin
      exec_q <= exec;
      if (exec) begin
        cmd_q <= cmd;
        res_q <= res_d;
      end
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);

  AST_RESET_STATE: assert property ($fell(i_sys_rst) |-> // RULE1
    pc_q == 16'h0000 && psw_q == 8'h00)
    else $error("pc or status not zero after reset");
  AST_ADD_CARRY: assert property (exec_q && cmd_q.op == OP_ADD |-> // RULE2
    psw_q[7] == (({1'b0, $past(acc_q)} + {1'b0, $past(opa_q)}) > 9'h0FF))
    else $error("add carry wrong");
  AST_ADD_AUX: assert property (exec_q && cmd_q.op == OP_ADD |-> // RULE3
    psw_q[6] == (({1'b0, $past(acc_q[3:0])} + {1'b0, $past(opa_q[3:0])}) > 5'h0F))
    else $error("aux carry wrong");
  AST_ADD_OVF: assert property (exec_q && cmd_q.op == OP_ADD |-> psw_q[2] == // RULE5
    ($past(acc_q[7]) == $past(opa_q[7]) && acc_q[7] != $past(acc_q[7])))
    else $error("overflow wrong");
  AST_CLEAR_OVF: assert property (exec_q && cmd_q.op == OP_CLEAR_OVF |-> !psw_q[2]) // RULE6
    else $error("overflow not cleared");
  AST_PARITY_READ: assert property (i_avs_read && !wait_q && i_avs_address == PSW_OFS // RULE7
    |-> o_avs_readdata[0] == ~^acc_q)
    else $error("parity wrong");
  AST_BANK_REG: assert property (exec_q && cmd_q.op == OP_REG_DIRECT |-> // RULE10
    res_q.addr == {11'h000, $past(psw_q[4:3]), cmd_q.sel})
    else $error("bank register address wrong");
  AST_SHORT_JUMP: assert property (exec_q && cmd_q.op == OP_SHORT_JUMP |-> // RULE12
    pc_q == $past(pc_q) + 16'h0002 + {{8{cmd_q.rel[7]}}, cmd_q.rel})
    else $error("short jump target wrong");
  AST_DEC_BRANCH: assert property (exec_q && cmd_q.op == OP_DECREMENT_BRANCH |-> // RULE18
    res_q.taken == ($past(opa_q) != 8'h01))
    else $error("decrement branch decision wrong");
  AST_COMPARE_CARRY: assert property (exec_q && cmd_q.op == OP_COMPARE_BRANCH |-> // RULE19
    psw_q[7] == ($past(opa_q) < $past(opb_q[7:0])))
    else $error("compare carry wrong");
  AST_USER_FLAG: assert property (exec_q |-> psw_q[5] == $past(psw_q[5])) // RULE21
    else $error("user flag altered by operation");
  AST_ACC_ZERO: assert property (exec_q && cmd_q.op == OP_JUMP_ACC_ZERO |-> // RULE17
    res_q.taken == ($past(acc_q) == 8'h00))
    else $error("zero jump decision wrong");

  COV_SHORT_BACK: cover property (exec_q && cmd_q.op == OP_SHORT_JUMP && cmd_q.rel[7]);
  COV_LOOP_END: cover property (exec_q && cmd_q.op == OP_DECREMENT_BRANCH && !res_q.taken);
  COV_CMP_BELOW: cover property (exec_q && cmd_q.op == OP_COMPARE_BRANCH && psw_q[7]);
  COV_READ: cover property (i_avs_read && !wait_q);
endmodule
`default_nettype wire

// ==== test/fab_mem_model.sv ====
// fab_mem_model: program memory that answers the core's indexed lookups
// assumes a 16-bit code address; data follow one rising edge later
`timescale 1ns/100ps
`default_nettype none
module fab_mem_model (
  input wire logic i_core_clk,
  input wire logic [15:0] i_addr,
  output logic [7:0] o_rdata
);
  // ------------------------------------------------------------
  // read-only table
  // ------------------------------------------------------------
  // no write port: a lookup can never disturb program memory
  always_ff @(posedge i_core_clk) begin
    o_rdata <= i_addr[7:0] ^ i_addr[15:8] ^ 8'h5A;
  end
endmodule
`default_nettype wire

// ==== test/test_cpu_flags_addressing_branching.sv ====
// test_cpu_flags_addressing_branching: register-level bench for fab_core
// assumes the fab_pkg register map and a one-wait-state Avalon-MM slave
`timescale 1ns/100ps
`default_nettype none
module test_cpu_flags_addressing_branching;
  import fab_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] adr = 8'h00;
  logic rd_en = 1'b0;
  logic wr_en = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic [3:0] be = 4'hF;
  logic [31:0] rdat;
  logic wreq;
  logic [15:0] pc_o;
  logic [1:0] bank_o;
  logic [15:0] m_adr = 16'h0;
  logic [7:0] m_dat;
  logic [31:0] q;
  int n_fail = 0;
  int tests_run = 0;

  always #12.5 clk = ~clk;

  fab_core u_dut (
    .i_core_clk(clk), .i_sys_rst(rst), .i_avs_address(adr), .i_avs_read(rd_en),
    .i_avs_write(wr_en), .i_avs_writedata(wdat), .i_avs_byteenable(be),
    .o_avs_readdata(rdat), .o_avs_waitrequest(wreq), .o_pc(pc_o), .o_bank_sel(bank_o)
  );
  fab_mem_model u_mem (.i_core_clk(clk), .i_addr(m_adr), .o_rdata(m_dat));

  // ------------------------------------------------------------
  // reporting and bus access
  // ------------------------------------------------------------
  task automatic summarize;
    if (n_fail == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // right after an edge the registered waitrequest and read data still show what it sampled
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    adr <= a;
    wr_en <= wr;
    rd_en <= ~wr;
    wdat <= d;
    @(posedge clk);
    while (wreq !== 1'b0 && n < 20) begin
      @(posedge clk);
      n++;
    end
    if (n >= 20) begin
      n_fail++;
      summarize();
    end
    q = rdat;
    wr_en <= 1'b0;
    rd_en <= 1'b0;
  endtask
  task automatic w(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic r(input logic [7:0] a);
    bus(1'b0, a, 32'h0);
  endtask
  task automatic ex(input fab_op_e op, input logic [2:0] sel, input logic [7:0] rel);
    fab_cmd_s c;
    c = '0;
    c.op = op;
    c.sel = sel;
    c.rel = rel;
    w(CMD_OFS, c);
  endtask

  // ------------------------------------------------------------
  // operation scenarios
  // ------------------------------------------------------------
  // status preset: user flag set, bank 2, overflow clear
  task automatic arith(input fab_op_e op, input logic [7:0] a, input logic [7:0] b, input logic ci);
    logic [7:0] bb;
    logic c0;
    logic [8:0] s;
    logic [4:0] h;
    logic ov;
    bb = (op == OP_SUB_BORROW) ? ~b : b;
    c0 = (op == OP_ADD) ? 1'b0 : ci;
    s = {1'b0, a} + {1'b0, bb} + {8'h0, c0};
    h = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, c0};
    ov = (a[7] == bb[7]) && (s[7] != a[7]);
    w(ACC_OFS, {24'h0, a});
    w(PSW_OFS, {24'h0, ci, 7'h30});
    w(OPA_OFS, {24'h0, b});
    ex(op, 3'h0, 8'h00);
    r(ACC_OFS);
    chk(q, {24'h0, s[7:0]});
    r(PSW_OFS);
    chk(q, {24'h0, s[8], h[4], 3'b110, ov, 1'b0, ~^s[7:0]});
  endtask
  task automatic rot(input fab_op_e op, input logic [7:0] a, input logic ci, input logic [8:0] e);
    w(ACC_OFS, {24'h0, a});
    w(PSW_OFS, {24'h0, ci, 7'h00});
    ex(op, 3'h0, 8'h00);
    r(ACC_OFS);
    chk(q, {24'h0, e[7:0]});
    r(PSW_OFS);
    chk({31'h0, q[7]}, {31'h0, e[8]});
  endtask
  // eb[1] set: the operation leaves no bit result to compare
  task automatic bop(input fab_op_e op, input logic ci, input logic bv, input logic ec,
                     input logic [1:0] eb);
    w(PSW_OFS, {24'h0, ci, 7'h20});
    w(OPA_OFS, {31'h0, bv});
    ex(op, 3'h0, 8'h00);
    r(PSW_OFS);
    chk({30'h0, q[7], q[5]}, {30'h0, ec, 1'b1});
    if (!eb[1]) begin
      r(RES_OFS);
      chk({31'h0, q[0]}, {31'h0, eb[0]});
    end
  endtask
  // every jump starts from 1000h; tk[1] or dat[8] set skips that compare
  task automatic jmp(input fab_op_e op, input logic ci, input logic [7:0] acc,
                     input logic [7:0] opa, input logic [15:0] opb, input logic [7:0] rel,
                     input logic [15:0] epc, input logic [1:0] tk, input logic [8:0] dat,
                     input logic ec);
    w(PC_OFS, 32'h1000);
    w(PSW_OFS, {24'h0, ci, 7'h00});
    w(ACC_OFS, {24'h0, acc});
    w(OPA_OFS, {24'h0, opa});
    w(OPB_OFS, {16'h0, opb});
    ex(op, 3'h0, rel);
    r(PC_OFS);
    chk(q, {16'h0, epc});
    chk({16'h0, pc_o}, {16'h0, epc});
    r(RES_OFS);
    if (!tk[1]) chk({31'h0, q[8]}, {31'h0, tk[0]});
    if (!dat[8]) chk({24'h0, q[7:0]}, {24'h0, dat[7:0]});
    r(PSW_OFS);
    chk({31'h0, q[7]}, {31'h0, ec});
  endtask

  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    r(PC_OFS);
    chk(q, 32'h0);
    r(PSW_OFS);
    chk(q, 32'h01);
    r(SP_OFS);
    chk(q, 32'h07);
    r(DATA_POINTER_OFS);
    chk(q, 32'h0);
    w(8'h40, 32'hFFFF_FFFF);
    r(8'h40);
    chk(q, 32'h0);
    w(PC_OFS, 32'h1234);
    be <= 4'h1;
    w(PC_OFS, 32'hFFFF_FFAB);
    be <= 4'hF;
    r(PC_OFS);
    chk(q, 32'h12AB);
    w(PSW_OFS, 32'hFF);
    r(PSW_OFS);
    chk(q, 32'hFD);
    arith(OP_ADD, 8'h7F, 8'h01, 1'b1);
    arith(OP_ADD, 8'h80, 8'hFF, 1'b0);
    arith(OP_ADD_CARRY, 8'h0F, 8'h00, 1'b1);
    arith(OP_SUB_BORROW, 8'h80, 8'h01, 1'b1);
    arith(OP_SUB_BORROW, 8'h00, 8'h01, 1'b0);
    arith(OP_SUB_BORROW, 8'h10, 8'h01, 1'b1);
    rot(OP_ROT_LEFT_C, 8'h81, 1'b0, 9'h102);
    rot(OP_ROT_RIGHT_C, 8'h01, 1'b1, 9'h180);
    w(PSW_OFS, 32'h24);
    ex(OP_CLEAR_OVF, 3'h0, 8'h00);
    r(PSW_OFS);
    chk({30'h0, q[5], q[2]}, 32'h2);
    for (int i = 0; i < 2; i++) begin
      w(OPA_OFS, (i == 0) ? 32'h40 : 32'hBF);
      ex(OP_BIT_TEST, 3'h0, 8'h00);
      r(PSW_OFS);
      chk({31'h0, q[2]}, (i == 0) ? 32'h1 : 32'h0);
    end
    bop(OP_AND_C_BIT, 1'b1, 1'b0, 1'b0, 2'b10);
    bop(OP_AND_C_NBIT, 1'b1, 1'b0, 1'b1, 2'b10);
    bop(OP_OR_C_BIT, 1'b0, 1'b1, 1'b1, 2'b10);
    bop(OP_OR_C_NBIT, 1'b0, 1'b1, 1'b0, 2'b10);
    bop(OP_MOVE_TO_C, 1'b0, 1'b1, 1'b1, 2'b10);
    bop(OP_MOVE_FROM_C, 1'b1, 1'b0, 1'b1, 2'b01);
    bop(OP_CLR_CARRY, 1'b1, 1'b1, 1'b0, 2'b10);
    bop(OP_SET_CARRY, 1'b0, 1'b0, 1'b1, 2'b10);
    bop(OP_CMPL_CARRY, 1'b1, 1'b0, 1'b0, 2'b10);
    bop(OP_CLR_BIT, 1'b0, 1'b1, 1'b0, 2'b00);
    bop(OP_SET_BIT, 1'b1, 1'b0, 1'b1, 2'b01);
    bop(OP_CMPL_BIT, 1'b0, 1'b1, 1'b0, 2'b00);
    for (int b = 0; b < 4; b++) begin
      w(PSW_OFS, b << 3);
      ex(OP_REG_DIRECT, 3'h5, 8'h00);
      chk({30'h0, bank_o}, b);
      r(RES_OFS);
      chk({16'h0, q[31:16]}, b * 8 + 5);
    end
    w(PSW_OFS, 32'h10);
    w(OPA_OFS, 32'h40);
    ex(OP_IND_BANK_REG, 3'h1, 8'h00);
    r(RES_OFS);
    chk({8'h0, q[31:16], q[7:0]}, 32'h0040_11);
    w(SP_OFS, 32'h30);
    ex(OP_IND_STACK, 3'h0, 8'h00);
    r(RES_OFS);
    chk({16'h0, q[31:16]}, 32'h30);
    w(DATA_POINTER_OFS, 32'hABCD);
    ex(OP_IND_POINTER, 3'h0, 8'h00);
    r(RES_OFS);
    chk({16'h0, q[31:16]}, 32'hABCD);
    w(DATA_POINTER_OFS, 32'hFFF0);
    w(ACC_OFS, 32'h20);
    ex(OP_FETCH_INDEX_PTR, 3'h0, 8'h00);
    r(RES_OFS);
    chk({16'h0, q[31:16]}, 32'h0010);
    m_adr <= q[31:16];
    @(posedge clk);
    @(negedge clk);
    w(ACC_OFS, {24'h0, m_dat});
    r(PSW_OFS);
    chk({23'h0, m_dat, q[0]}, 32'h94);
    w(PC_OFS, 32'h2000);
    ex(OP_FETCH_INDEX_PC, 3'h0, 8'h00);
    r(RES_OFS);
    chk({16'h0, q[31:16]}, 32'h204B);
    ex(OP_JUMP_INDEXED, 3'h0, 8'h00);
    r(PC_OFS);
    chk(q, 32'h003A);
    jmp(OP_SHORT_JUMP, 1'b0, 8'h00, 8'h00, 16'h0, 8'h80, 16'h0F82, 2'b10, 9'h100, 1'b0);
    jmp(OP_JUMP_CARRY_SET, 1'b1, 8'h00, 8'h00, 16'h0, 8'h7F, 16'h1081, 2'b01, 9'h100, 1'b1);
    jmp(OP_JUMP_CARRY_CLEAR, 1'b1, 8'h00, 8'h00, 16'h0, 8'h10, 16'h1002, 2'b00, 9'h100, 1'b1);
    jmp(OP_JUMP_BIT_SET, 1'b0, 8'h00, 8'h01, 16'h0, 8'h10, 16'h1013, 2'b01, 9'h100, 1'b0);
    jmp(OP_JUMP_BIT_CLEAR, 1'b0, 8'h00, 8'h01, 16'h0, 8'h10, 16'h1003, 2'b00, 9'h100, 1'b0);
    jmp(OP_JUMP_BIT_AND_CLEAR, 1'b0, 8'h00, 8'h01, 16'h0, 8'hF0, 16'h0FF3, 2'b01, 9'h000, 1'b0);
    jmp(OP_JUMP_ACC_ZERO, 1'b0, 8'h00, 8'h00, 16'h0, 8'h04, 16'h1006, 2'b01, 9'h100, 1'b0);
    jmp(OP_JUMP_ACC_NONZERO, 1'b0, 8'h00, 8'h00, 16'h0, 8'h04, 16'h1002, 2'b00, 9'h100, 1'b0);
    jmp(OP_DECREMENT_BRANCH, 1'b0, 8'h00, 8'h01, 16'h0, 8'h20, 16'h1003, 2'b00, 9'h000, 1'b0);
    jmp(OP_DECREMENT_BRANCH, 1'b0, 8'h00, 8'h00, 16'h0, 8'h20, 16'h1023, 2'b01, 9'h0FF, 1'b0);
    jmp(OP_COMPARE_BRANCH, 1'b0, 8'h00, 8'h03, 16'h5, 8'h08, 16'h100B, 2'b01, 9'h100, 1'b1);
    jmp(OP_COMPARE_BRANCH, 1'b1, 8'h00, 8'h05, 16'h5, 8'h08, 16'h1003, 2'b00, 9'h100, 1'b0);
    jmp(OP_COMPARE_BRANCH, 1'b1, 8'h00, 8'h06, 16'h5, 8'h08, 16'h100B, 2'b01, 9'h100, 1'b0);
    jmp(OP_LONG_JUMP, 1'b0, 8'h00, 8'h00, 16'hBEEF, 8'h00, 16'hBEEF, 2'b10, 9'h100, 1'b0);
    jmp(OP_ABSOLUTE_JUMP, 1'b0, 8'h00, 8'h00, 16'h1234, 8'h00, 16'h1234, 2'b10, 9'h100, 1'b0);
    w(SP_OFS, 32'h40);
    jmp(OP_SUBROUTINE_RETURN, 1'b0, 8'h00, 8'h00, 16'h4321, 8'h00, 16'h4321, 2'b10, 9'h100, 1'b0);
    jmp(OP_INTERRUPT_RETURN, 1'b0, 8'h00, 8'h00, 16'h4321, 8'h00, 16'h4321, 2'b10, 9'h100, 1'b0);
    r(SP_OFS);
    chk(q, 32'h3C);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    r(PC_OFS);
    chk({pc_o, q[15:0]}, 32'h0);
    summarize();
  end
endmodule
`default_nettype wire
